/* File: rsc_report.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"

// Behaviour
// RULE1 - No passing sample for a bit over the range reports code 0x1 with nibble and bit.
// RULE2 - Left edge not found reports code 0x2 with nibble and bit.
// RULE3 - Read data not back within the wait reports code 0xF with nibble and bit; the code always reports bit 0.
// RULE4 - Keep rise and fall left edge taps for each rank and nibble.
// RULE5 - Keep rise and fall right edge taps for each rank and nibble.
// RULE6 - Left edge declared only after 10 consecutive passing taps; else error.
// RULE7 - Each final delay is left plus half of right minus left.
// RULE8 - Each tap is judged over 64 read bursts.
// RULE9 - Recorded failure code and location hold until reset.
module rsc_report #(
	parameter int unsigned NRANK = 2,
	parameter int unsigned NNIB = 4,
	parameter int unsigned NB = 4,
	parameter int unsigned MAX_TAP = 511,
	parameter int unsigned TMO_CYC = `RSC_TMO_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	// Capture delay taps
	output logic [`RSC_TAP_W-1:0] rise_capture_delay,
	output logic [`RSC_TAP_W-1:0] fall_capture_delay,
	// Read burst compare path
	output logic rd_req,
	input wire logic rd_valid,
	input wire logic [NB-1:0] rise_ok,
	input wire logic [NB-1:0] fall_ok
);

	localparam int unsigned NENT = NRANK * NNIB;
	localparam logic [`RSC_TAP_W-1:0] TAP_MAX = `RSC_TAP_W'(MAX_TAP);
	localparam logic [`RSC_TAP_W-1:0] WIN = `RSC_TAP_W'(`RSC_MIN_WIN);
	localparam logic [3:0] RUN_LAST = 4'(`RSC_MIN_WIN - 1);

	rsc_pkg::rsc_state_t state;
	rsc_pkg::rsc_edges_t edges [NENT];
	rsc_pkg::rsc_err_t err;
	logic [`RSC_TAP_W-1:0] tap_r, tap_f, first_r, first_f, left_r, left_f, right_r, right_f;
	logic [3:0] run_r, run_f;
	logic left_found_r, left_found_f, right_found_r, right_found_f;
	logic [NB-1:0] ever_pass;
	logic [7:0] cur_rank, cur_nib, sel;
	logic pending, done_seen;
	logic j_start, j_done, j_tmo;
	logic [NB-1:0] j_rise, j_fall;
	logic rise_pass, fall_pass, lr_hit, lf_hit, both_left, at_max;
	logic rr_stop, rf_stop, both_right;
	logic [NB-1:0] next_ever;
	logic fail_tmo, fail_left, fail_nopass, start_req;
	logic [`RSC_TAP_W-1:0] next_left_r, next_left_f;
	logic [31:0] next_rdata;

	// Flat entry index of a rank and nibble
	function automatic int unsigned idx_of(input logic [7:0] rank, input logic [7:0] nib);
		return 32'(rank) * NNIB + 32'(nib);
	endfunction : idx_of

	// Lowest bit that never passed
	function automatic logic [7:0] first_zero(input logic [NB-1:0] v);
		first_zero = 8'h00;
		for (int i = NB - 1; i >= 0; i--) begin
			if (!v[i]) begin
				first_zero = 8'(i);
			end
		end
	endfunction : first_zero

	function automatic logic [`RSC_TAP_W-1:0] center(input logic [`RSC_TAP_W-1:0] l,
		input logic [`RSC_TAP_W-1:0] r);
		return l + ((r - l) >> 1);
	endfunction : center

	// ----------------------------------------
	// Per-tap sampling
	// ----------------------------------------
	rsc_sample_judge #(
		.NB(NB),
		.BURSTS(`RSC_BURSTS),
		.TMO_CYC(TMO_CYC)
	) u_judge (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.start(j_start),
		.done(j_done),
		.timeout(j_tmo),
		.rise_pass(j_rise),
		.fall_pass(j_fall),
		.rd_req(rd_req),
		.rd_valid(rd_valid),
		.rise_ok(rise_ok),
		.fall_ok(fall_ok)
	);

	assign j_start = ((state == rsc_pkg::RSC_LEFT) || (state == rsc_pkg::RSC_RIGHT)) && !pending;
	assign rise_capture_delay = tap_r;
	assign fall_capture_delay = tap_f;

	// ----------------------------------------
	// Step decisions
	// ----------------------------------------
	always_comb begin
		rise_pass = &j_rise;
		fall_pass = &j_fall;
		lr_hit = !left_found_r && rise_pass && (run_r == RUN_LAST);
		lf_hit = !left_found_f && fall_pass && (run_f == RUN_LAST);
		both_left = (left_found_r || lr_hit) && (left_found_f || lf_hit);
		next_left_r = left_found_r ? left_r : ((run_r == 4'h0) ? tap_r : first_r);
		next_left_f = left_found_f ? left_f : ((run_f == 4'h0) ? tap_f : first_f);
		at_max = (tap_r == TAP_MAX) || (tap_f == TAP_MAX);
		rr_stop = !right_found_r && (!rise_pass || tap_r == TAP_MAX);
		rf_stop = !right_found_f && (!fall_pass || tap_f == TAP_MAX);
		both_right = (right_found_r || rr_stop) && (right_found_f || rf_stop);
		next_ever = ever_pass | j_rise | j_fall;
		fail_tmo = pending && j_done && j_tmo;
		fail_left = (state == rsc_pkg::RSC_LEFT) && j_done && !j_tmo && !both_left && at_max;
		fail_nopass = fail_left && (next_ever != {NB{1'b1}});
		start_req = wr_stb && (addr == `RSC_OFS_CTRL) && wdata[`RSC_CTRL_START]
			&& (wdata[`RSC_IDX_LO +: `RSC_IDX_W] < 8'(NRANK))
			&& (wdata[`RSC_NIB_LO +: `RSC_IDX_W] < 8'(NNIB));
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= rsc_pkg::RSC_IDLE;
			pending <= 1'b0;
			done_seen <= 1'b0;
			cur_rank <= 8'h00;
			cur_nib <= 8'h00;
		end else begin
			if (j_start) begin
				pending <= 1'b1;
			end else if (j_done) begin
				pending <= 1'b0;
			end
			case (state)
				rsc_pkg::RSC_IDLE: begin
					if (start_req) begin
						cur_rank <= wdata[`RSC_IDX_LO +: `RSC_IDX_W];
						cur_nib <= wdata[`RSC_NIB_LO +: `RSC_IDX_W];
						done_seen <= 1'b0;
						state <= rsc_pkg::RSC_LEFT;
					end
				end
				rsc_pkg::RSC_LEFT: begin
					if (fail_tmo || fail_left) begin
						state <= rsc_pkg::RSC_FAIL;
					end else if (j_done && both_left) begin
						state <= rsc_pkg::RSC_RIGHT;
					end
				end
				rsc_pkg::RSC_RIGHT: begin
					if (fail_tmo) begin
						state <= rsc_pkg::RSC_FAIL;
					end else if (j_done && both_right) begin
						state <= rsc_pkg::RSC_DONE;
					end
				end
				rsc_pkg::RSC_DONE: begin
					done_seen <= 1'b1;
					state <= rsc_pkg::RSC_IDLE;
				end
				rsc_pkg::RSC_FAIL: begin
					state <= rsc_pkg::RSC_FAIL; // RULE9
				end
				default: begin
					state <= rsc_pkg::RSC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Tap search
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tap_r <= '0;
			tap_f <= '0;
			first_r <= '0;
			first_f <= '0;
			left_r <= '0;
			left_f <= '0;
			right_r <= '0;
			right_f <= '0;
			run_r <= 4'h0;
			run_f <= 4'h0;
			left_found_r <= 1'b0;
			left_found_f <= 1'b0;
			right_found_r <= 1'b0;
			right_found_f <= 1'b0;
			ever_pass <= '0;
		end else if (state == rsc_pkg::RSC_IDLE && start_req) begin
			tap_r <= '0;
			tap_f <= '0;
			run_r <= 4'h0;
			run_f <= 4'h0;
			left_found_r <= 1'b0;
			left_found_f <= 1'b0;
			right_found_r <= 1'b0;
			right_found_f <= 1'b0;
			ever_pass <= '0;
		end else if (state == rsc_pkg::RSC_LEFT && j_done && !j_tmo) begin
			ever_pass <= next_ever;
			if (!left_found_r) begin
				run_r <= rise_pass ? run_r + 4'h1 : 4'h0; // RULE6
				first_r <= next_left_r;
				left_found_r <= lr_hit;
				left_r <= next_left_r;
			end
			if (!left_found_f) begin
				run_f <= fall_pass ? run_f + 4'h1 : 4'h0; // RULE6
				first_f <= next_left_f;
				left_found_f <= lf_hit;
				left_f <= next_left_f;
			end
			if (both_left) begin
				tap_r <= next_left_r + WIN;
				tap_f <= next_left_f + WIN;
				right_r <= next_left_r + WIN - 1'b1;
				right_f <= next_left_f + WIN - 1'b1;
			end else if (!at_max) begin
				tap_r <= tap_r + 1'b1;
				tap_f <= tap_f + 1'b1;
			end
		end else if (state == rsc_pkg::RSC_RIGHT && j_done && !j_tmo) begin
			if (!right_found_r) begin
				right_found_r <= rr_stop;
				right_r <= rise_pass ? tap_r : right_r;
				tap_r <= rr_stop ? tap_r : tap_r + 1'b1;
			end
			if (!right_found_f) begin
				right_found_f <= rf_stop;
				right_f <= fall_pass ? tap_f : right_f;
				tap_f <= rf_stop ? tap_f : tap_f + 1'b1;
			end
		end else if (state == rsc_pkg::RSC_DONE) begin
			tap_r <= center(left_r, right_r); // RULE7
			tap_f <= center(left_f, right_f); // RULE7
		end
	end

	// ----------------------------------------
	// Edge store
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NENT; i++) begin
				edges[i] <= '0;
			end
		end else if (state == rsc_pkg::RSC_LEFT && j_done && !j_tmo && both_left) begin
			edges[idx_of(cur_rank, cur_nib)].left <= {next_left_r, next_left_f}; // RULE4
		end else if (state == rsc_pkg::RSC_DONE) begin
			edges[idx_of(cur_rank, cur_nib)].right <= {right_r, right_f}; // RULE5
		end
	end

	// ----------------------------------------
	// Failure record
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			err <= '0;
		end else if (err.code == `RSC_ERR_NONE) begin // RULE9
			if (fail_tmo) begin
				err <= '{`RSC_ERR_TMO, cur_nib, 8'h00}; // RULE3
			end else if (fail_nopass) begin
				err <= '{`RSC_ERR_NOPASS, cur_nib, first_zero(next_ever)}; // RULE1
			end else if (fail_left) begin
				err <= '{`RSC_ERR_NOLEFT, cur_nib, first_zero(j_rise & j_fall)}; // RULE2
			end
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel <= 8'h00;
		end else if (wr_stb && addr == `RSC_OFS_SEL) begin
			sel <= wdata[7:0];
		end
	end

	always_comb begin
		rsc_pkg::rsc_edges_t e;
		e = (sel < 8'(NENT)) ? edges[32'(sel)] : '0;
		next_rdata = 32'h00000000;
		case (addr)
			`RSC_OFS_CTRL: next_rdata = {8'h00, cur_nib, cur_rank, 8'h00};
			`RSC_OFS_STATUS: next_rdata = {8'h00, err.bit_pos, err.nibble, err.code,
				1'b0, state == rsc_pkg::RSC_FAIL, done_seen, pending};
			`RSC_OFS_SEL: next_rdata = {24'h000000, sel};
			`RSC_OFS_LEFT: next_rdata = {7'h00, e.left.fall, 7'h00, e.left.rise};
			`RSC_OFS_RIGHT: next_rdata = {7'h00, e.right.fall, 7'h00, e.right.rise};
			`RSC_OFS_CENTER: next_rdata = {7'h00, center(e.left.fall, e.right.fall),
				7'h00, center(e.left.rise, e.right.rise)};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= rd_stb ? next_rdata : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	nopass_code_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE1
		(fail_nopass && !fail_tmo && err.code == `RSC_ERR_NONE)
		|=> err.code == `RSC_ERR_NOPASS && err.nibble == $past(cur_nib))
		else $error("missing no-pass failure code");

	noleft_code_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE2
		(fail_left && !fail_nopass && err.code == `RSC_ERR_NONE)
		|=> err.code == `RSC_ERR_NOLEFT ##1 state == rsc_pkg::RSC_FAIL)
		else $error("missing left edge failure code");

	tmo_code_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE3
		(j_tmo && err.code == `RSC_ERR_NONE) |=> err.code == `RSC_ERR_TMO)
		else $error("missing timeout failure code");

	left_store_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE4
		$rose(state == rsc_pkg::RSC_RIGHT)
		|-> edges[idx_of(cur_rank, cur_nib)].left == {left_r, left_f})
		else $error("left edge taps not stored");

	right_store_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE5
		state == rsc_pkg::RSC_DONE
		|=> edges[idx_of(cur_rank, cur_nib)].right == {$past(right_r), $past(right_f)})
		else $error("right edge taps not stored");

	left_run_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE6
		$rose(left_found_r) |-> $past(run_r) == RUN_LAST && $past(rise_pass) && $past(j_done))
		else $error("left edge declared without full passing run");

	center_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE7
		state == rsc_pkg::RSC_DONE ##1 state == rsc_pkg::RSC_IDLE
		|-> 10'(rise_capture_delay) * 2 <= 10'($past(left_r)) + 10'($past(right_r))
		&& 10'(rise_capture_delay) * 2 + 1 >= 10'($past(left_r)) + 10'($past(right_r)))
		else $error("final delay is not the window center");

	err_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE9
		err.code != `RSC_ERR_NONE |=> $stable(err) && state == rsc_pkg::RSC_FAIL)
		else $error("failure record changed before reset");

endmodule : rsc_report
`default_nettype wire

/* File: rsc_params.svh */
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ----------------------------------------
// Search and sampling constants
// ----------------------------------------
`define RSC_TAP_W 9
`define RSC_MIN_WIN 10
`define RSC_BURSTS 64
`define RSC_CLK_NS 50
`define RSC_TMO_NS 10000
`define RSC_TMO_CYC (`RSC_TMO_NS / `RSC_CLK_NS)

// ----------------------------------------
// Failure codes
// ----------------------------------------
`define RSC_ERR_NONE 4'h0
`define RSC_ERR_NOPASS 4'h1
`define RSC_ERR_NOLEFT 4'h2
`define RSC_ERR_TMO 4'hF

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define RSC_OFS_CTRL 8'h00
`define RSC_OFS_STATUS 8'h04
`define RSC_OFS_SEL 8'h08
`define RSC_OFS_LEFT 8'h0C
`define RSC_OFS_RIGHT 8'h10
`define RSC_OFS_CENTER 8'h14
`define RSC_CTRL_START 0
`define RSC_IDX_LO 8
`define RSC_IDX_W 8
`define RSC_NIB_LO 16
`define RSC_FALL_LO 16

`endif

/* File: rsc_pkg.sv */
`default_nettype none

package rsc_pkg;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [8:0] rise;
		logic [8:0] fall;
	} rsc_tap_pair_t;

	typedef struct packed {
		rsc_tap_pair_t left;
		rsc_tap_pair_t right;
	} rsc_edges_t;

	typedef struct packed {
		logic [3:0] code;
		logic [7:0] nibble;
		logic [7:0] bit_pos;
	} rsc_err_t;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		RSC_IDLE = 3'b000,
		RSC_LEFT = 3'b001,
		RSC_RIGHT = 3'b010,
		RSC_DONE = 3'b011,
		RSC_FAIL = 3'b100
	} rsc_state_t;

endpackage : rsc_pkg

`default_nettype wire

/* File: rsc_sample_judge.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"

module rsc_sample_judge #(
	parameter int unsigned NB = 4,
	parameter int unsigned BURSTS = `RSC_BURSTS,
	parameter int unsigned TMO_CYC = `RSC_TMO_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Control
	input wire logic start,
	output logic done,
	output logic timeout,
	output logic [NB-1:0] rise_pass,
	output logic [NB-1:0] fall_pass,
	// Read path
	output logic rd_req,
	input wire logic rd_valid,
	input wire logic [NB-1:0] rise_ok,
	input wire logic [NB-1:0] fall_ok
);

	logic active;
	logic [7:0] cnt;
	logic [15:0] wait_cnt;
	logic [NB-1:0] acc_r;
	logic [NB-1:0] acc_f;
	logic last;
	logic tmo_now;

	assign last = (cnt == 8'(BURSTS - 1));
	assign tmo_now = active && !rd_valid && (wait_cnt == 16'(TMO_CYC));

	// ----------------------------------------
	// Burst counting and pass accumulation
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			active <= 1'b0;
			cnt <= 8'h00;
			wait_cnt <= 16'h0000;
			acc_r <= '0;
			acc_f <= '0;
			rd_req <= 1'b0;
			done <= 1'b0;
			timeout <= 1'b0;
			rise_pass <= '0;
			fall_pass <= '0;
		end else begin
			rd_req <= 1'b0;
			done <= 1'b0;
			timeout <= 1'b0;
			if (start && !active) begin
				active <= 1'b1;
				cnt <= 8'h00;
				wait_cnt <= 16'h0000;
				acc_r <= '1;
				acc_f <= '1;
				rd_req <= 1'b1;
			end else if (active && rd_valid) begin
				wait_cnt <= 16'h0000;
				cnt <= cnt + 8'h01; // RULE8
				if (last) begin
					active <= 1'b0;
					done <= 1'b1;
					rise_pass <= acc_r & rise_ok;
					fall_pass <= acc_f & fall_ok;
				end else begin
					acc_r <= acc_r & rise_ok;
					acc_f <= acc_f & fall_ok;
					rd_req <= 1'b1;
				end
			end else if (tmo_now) begin
				active <= 1'b0;
				done <= 1'b1;
				timeout <= 1'b1; // RULE3
				rise_pass <= '0;
				fall_pass <= '0;
			end else if (active) begin
				wait_cnt <= wait_cnt + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	burst_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE8
		(done && !timeout) |-> $past(cnt) == 8'(BURSTS - 1) && $past(rd_valid))
		else $error("judge finished without the full burst count");

	tmo_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE3
		timeout |-> done && $past(wait_cnt) == 16'(TMO_CYC) && !$past(rd_valid))
		else $error("timeout raised before the allotted wait");

endmodule : rsc_sample_judge
`default_nettype wire

/* File: rsc_dram_model.sv */
`timescale 1ns/1ns
`default_nettype none

module rsc_dram_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Burst request and tap settings
	input wire logic rd_req,
	input wire logic [8:0] rise_tap,
	input wire logic [8:0] fall_tap,
	// Scenario controls
	input wire logic [8:0] rise_lo,
	input wire logic [8:0] rise_hi,
	input wire logic [8:0] fall_lo,
	input wire logic [8:0] fall_hi,
	input wire logic [3:0] dead_bits,
	input wire logic mute,
	input wire logic [7:0] lat,
	// Compare results
	output logic rd_valid,
	output logic [3:0] rise_ok,
	output logic [3:0] fall_ok
);
	logic busy;
	logic [7:0] cnt;

	// Outside a reply the result lines toggle so stale values are never trusted
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			rd_valid <= 1'b0;
			rise_ok <= 4'hA;
			fall_ok <= 4'h5;
		end else begin
			rd_valid <= 1'b0;
			rise_ok <= ~rise_ok;
			fall_ok <= ~fall_ok;
			if (rd_req && !mute) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'b0;
				rd_valid <= 1'b1;
				rise_ok <= (rise_tap >= rise_lo && rise_tap <= rise_hi) ? ~dead_bits : 4'h0;
				fall_ok <= (fall_tap >= fall_lo && fall_tap <= fall_hi) ? ~dead_bits : 4'h0;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule : rsc_dram_model

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"

module testbench;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [31:0] rdata;
	logic [8:0] rise_capture_delay;
	logic [8:0] fall_capture_delay;
	logic rd_req;
	logic rd_valid;
	logic [3:0] rise_ok;
	logic [3:0] fall_ok;
	logic [8:0] rise_lo = 9'h000, rise_hi = 9'h000, fall_lo = 9'h000, fall_hi = 9'h000;
	logic [3:0] dead_bits = 4'h0;
	logic mute = 1'b0;
	logic [7:0] lat = 8'h00;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int bursts = 0;

	always #25 ref_clk = ~ref_clk;

	rsc_report #(.NRANK(2), .NNIB(4), .NB(4), .MAX_TAP(40), .TMO_CYC(20)) uut (
		.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .rise_capture_delay(rise_capture_delay),
		.fall_capture_delay(fall_capture_delay), .rd_req(rd_req), .rd_valid(rd_valid),
		.rise_ok(rise_ok), .fall_ok(fall_ok));

	rsc_dram_model dram (
		.ref_clk(ref_clk), .rst_b(rst_b), .rd_req(rd_req), .rise_tap(rise_capture_delay),
		.fall_tap(fall_capture_delay), .rise_lo(rise_lo), .rise_hi(rise_hi), .fall_lo(fall_lo),
		.fall_hi(fall_hi), .dead_bits(dead_bits), .mute(mute), .lat(lat), .rd_valid(rd_valid),
		.rise_ok(rise_ok), .fall_ok(fall_ok));

	// ----------------------------------------
	// Common tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge ref_clk) begin
		cycles++;
		if (rd_req === 1'b1) begin
			bursts++;
		end
		if (cycles == 90000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic do_reset;
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		bursts = 0;
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic run_cal(input logic [7:0] rank, input logic [7:0] nib, output logic [31:0] s);
		wr(`RSC_OFS_CTRL, {8'h00, nib, rank, 8'h01});
		s = 32'h00000000;
		for (int i = 0; i < 30000 && s[1] !== 1'b1 && s[2] !== 1'b1; i++) begin
			rd(`RSC_OFS_STATUS, s);
		end
	endtask : run_cal

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_vals;
		logic [31:0] d;
		do_reset();
		rd(`RSC_OFS_STATUS, d);
		check(d, 32'h00000000, "status after reset");
		rd(`RSC_OFS_LEFT, d);
		check(d, 32'h00000000, "left after reset");
		rd(8'h40, d);
		check(d, 32'h00000000, "unmapped read");
		wr(`RSC_OFS_SEL, 32'h00000005);
		rd(`RSC_OFS_SEL, d);
		check(d, 32'h00000005, "select readback");
	endtask : t_reset_vals

	task automatic t_pass;
		logic [31:0] d;
		do_reset();
		rise_lo <= 9'h005;
		rise_hi <= 9'h019;
		fall_lo <= 9'h008;
		fall_hi <= 9'h01E;
		dead_bits <= 4'h0;
		mute <= 1'b0;
		lat <= 8'h06;
		run_cal(8'h01, 8'h02, d);
		check(d, 32'h00000002, "status after pass");
		check({23'h000000, rise_capture_delay}, 32'h0000000F, "rise delay center");
		check({23'h000000, fall_capture_delay}, 32'h00000013, "fall delay center");
		check(bursts, 32'h00000800, "bursts over 32 taps");
		rd(`RSC_OFS_CTRL, d);
		check(d, 32'h00020100, "control readback");
		wr(`RSC_OFS_SEL, 32'h00000006);
		rd(`RSC_OFS_LEFT, d);
		check(d, 32'h00080005, "left edges");
		rd(`RSC_OFS_RIGHT, d);
		check(d, 32'h001E0019, "right edges");
		rd(`RSC_OFS_CENTER, d);
		check(d, 32'h0013000F, "center");
		wr(`RSC_OFS_SEL, 32'h00000000);
		rd(`RSC_OFS_RIGHT, d);
		check(d, 32'h00000000, "untouched entry");
	endtask : t_pass

	task automatic t_nopass;
		logic [31:0] d;
		do_reset();
		dead_bits <= 4'h4;
		lat <= 8'h00;
		run_cal(8'h00, 8'h03, d);
		check(d, 32'h00020314, "no pass status");
	endtask : t_nopass

	task automatic t_noleft;
		logic [31:0] d;
		do_reset();
		rise_lo <= 9'h005;
		rise_hi <= 9'h00D;
		fall_lo <= 9'h000;
		fall_hi <= 9'h028;
		dead_bits <= 4'h0;
		lat <= 8'h01;
		run_cal(8'h01, 8'h01, d);
		check(d, 32'h00000124, "nine tap window");
		check(d, 32'h00000124, "no left status");
	endtask : t_noleft

	task automatic t_timeout;
		logic [31:0] d;
		do_reset();
		mute <= 1'b1;
		run_cal(8'h00, 8'h02, d);
		check(d, 32'h000002F4, "timeout status");
		mute <= 1'b0;
		wr(`RSC_OFS_CTRL, 32'h00010101);
		repeat (100) @(posedge ref_clk);
		rd(`RSC_OFS_STATUS, d);
		check(d, 32'h000002F4, "held error");
	endtask : t_timeout

	initial begin
		t_reset_vals();
		t_pass();
		t_nopass();
		t_noleft();
		t_timeout();
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
